// ===== hw/cpr_regs.sv
// Purpose: programmer register set: data/address regs, stack pointers, pc,
//          status word, alternate space codes, vector base, operand bus access
// Assumes: all requests come from core logic on ref_clk, one at a time
// Notes: register read results appear one cycle after the request; operand bus reads appear with mem_done_q
`timescale 1ns/1ps
`default_nettype none
module cpr_regs (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic dr_wr_en,
    input wire logic [2:0] dr_wr_idx,
    input wire cpr_pkg::cpr_size_t dr_wr_size,
    input wire logic [31:0] dr_wr_data,
    input wire logic [2:0] dr_rd_idx,
    input wire cpr_pkg::cpr_size_t dr_rd_size,
    output logic [31:0] dr_rd_data_q,
    input wire logic ar_wr_en,
    input wire logic [2:0] ar_wr_idx,
    input wire cpr_pkg::cpr_size_t ar_wr_size,
    input wire logic [31:0] ar_wr_data,
    input wire logic [2:0] ar_rd_idx,
    input wire cpr_pkg::cpr_size_t ar_rd_size,
    output logic [31:0] ar_rd_data_q,
    output logic size_err_q,
    input wire logic pc_load,
    input wire logic [31:0] pc_load_val,
    input wire logic pc_inc,
    input wire logic [2:0] pc_inc_words,
    output logic [31:0] next_instr_pointer_q,
    input wire logic cc_upd_en,
    input wire logic [4:0] cc_upd_val,
    input wire logic sw_wr_en,
    input wire logic sw_rd_en,
    input wire logic sw_ccr_only,
    input wire logic [15:0] sw_wr_data,
    output logic [15:0] sw_rd_data_q,
    output logic [15:0] processor_status_word_q,
    input wire logic cm_en,
    input wire logic cm_write,
    input wire cpr_pkg::cpr_ctl_t cm_sel,
    input wire logic [31:0] cm_wdata,
    output logic [31:0] cm_rdata_q,
    output logic priv_viol_q,
    input wire logic [7:0] vec_num,
    output logic [31:0] vec_addr_q,
    input wire logic mem_req,
    input wire logic mem_rnw,
    input wire logic mem_prog,
    input wire logic mem_cpu_space,
    input wire logic mem_alt,
    input wire cpr_pkg::cpr_size_t mem_size,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata_q,
    output logic mem_done_q,
    output logic mem_busy_q,
    output logic addr_err_q,
    output logic bus_req_q,
    output logic bus_rnw_q,
    output logic [23:0] bus_addr_q,
    output logic [2:0] bus_fc_q,
    output logic bus_ustb_q,
    output logic bus_lstb_q,
    output logic [15:0] bus_wdata_q,
    input wire logic bus_ack,
    input wire logic [15:0] bus_rdata
);
    typedef enum logic [1:0] {BS_IDLE, BS_HI, BS_LO} cpr_bus_t;
    logic [31:0] dr_q [cpr_pkg::NUM_DREGS];
    logic [31:0] ar_q [cpr_pkg::NUM_AREGS];
    logic [31:0] usp_q, ssp_q, vbr_q;
    logic [2:0] sfc_q, dfc_q;
    logic [15:0] sw_d;
    logic [15:0] bus_hi_q;
    logic bus_long_q, bus_byte_q, bus_odd_q;
    logic [15:0] bus_lo_data_q;
    cpr_bus_t bs_q;

    function automatic logic [31:0] sext_src(input logic [31:0] v, input cpr_pkg::cpr_size_t s);
        sext_src = (s == cpr_pkg::SZ_LONG) ? v : {{16{v[15]}}, v[15:0]};
    endfunction : sext_src

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input cpr_pkg::cpr_size_t s);
        unique case (s)
            cpr_pkg::SZ_BYTE: merge = {o[31:8], n[7:0]};
            cpr_pkg::SZ_WORD: merge = {o[31:16], n[15:0]};
            default: merge = n;
        endcase
    endfunction : merge

    wire sup = processor_status_word_q[cpr_pkg::SW_S_BIT];
    wire ar_byte = ar_wr_en && ar_wr_size == cpr_pkg::SZ_BYTE;
    wire ar_ok = ar_wr_en && !ar_byte;
    wire [31:0] ar_new = sext_src(ar_wr_data, ar_wr_size);
    wire [31:0] sp_cur = sup ? ssp_q : usp_q;
    wire [31:0] ar_sel = (ar_rd_idx == 3'h7) ? sp_cur : ar_q[ar_rd_idx];
    wire [31:0] dr_sel = dr_q[dr_rd_idx];
    wire sw_full = (sw_wr_en || sw_rd_en) && !sw_ccr_only;
    wire cm_deny = cm_en && !sup;
    wire sw_deny = sw_full && !sup;
    wire alt_deny = mem_req && mem_alt && !sup && bs_q == BS_IDLE;
    wire sw_wr_ok = sw_wr_en && !sw_deny;
    wire [15:0] sw_wmask = sw_ccr_only ? cpr_pkg::SW_CCR_MASK : cpr_pkg::SW_IMPL_MASK;
    wire cm_wr_ok = cm_en && cm_write && sup;
    wire [2:0] fc_auto = mem_cpu_space ? cpr_pkg::FC_CPU_SPACE :
                         sup ? (mem_prog ? cpr_pkg::FC_SUP_PROG : cpr_pkg::FC_SUP_DATA) :
                         (mem_prog ? cpr_pkg::FC_USER_PROG : cpr_pkg::FC_USER_DATA);
    wire [2:0] fc_sel = mem_alt ? (mem_rnw ? sfc_q : dfc_q) : fc_auto;
    wire mis = mem_size != cpr_pkg::SZ_BYTE && mem_addr[0];
    wire [31:0] cm_sel_val = (cm_sel == cpr_pkg::CM_SFC) ? {29'h0, sfc_q} :
                             (cm_sel == cpr_pkg::CM_DFC) ? {29'h0, dfc_q} :
                             (cm_sel == cpr_pkg::CM_VBR) ? vbr_q : usp_q;
    wire [7:0] rd_lane = bus_odd_q ? bus_rdata[7:0] : bus_rdata[15:8];

    always_comb
    begin
        sw_d = processor_status_word_q;
        if (cc_upd_en)
            sw_d[4:0] = cc_upd_val;
        if (sw_wr_ok)
            sw_d = (sw_d & ~sw_wmask) | (sw_wr_data & sw_wmask);
    end

    genvar gi;
    generate
        for (gi = 0; gi < cpr_pkg::NUM_DREGS; gi++)
        begin : g_dr
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                    dr_q[gi] <= 32'h0000_0000;
                else if (dr_wr_en && dr_wr_idx == gi)
                    dr_q[gi] <= merge(dr_q[gi], dr_wr_data, dr_wr_size);
            end
        end
        for (gi = 0; gi < cpr_pkg::NUM_AREGS; gi++)
        begin : g_ar
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                    ar_q[gi] <= 32'h0000_0000;
                else if (ar_ok && ar_wr_idx == gi)
                    ar_q[gi] <= ar_new;
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            usp_q <= 32'h0000_0000;
            ssp_q <= 32'h0000_0000;
            sfc_q <= cpr_pkg::FC_RESET;
            dfc_q <= cpr_pkg::FC_RESET;
            vbr_q <= cpr_pkg::VBR_RESET;
            processor_status_word_q <= cpr_pkg::SW_RESET;
            next_instr_pointer_q <= cpr_pkg::PC_RESET;
            size_err_q <= 1'b0;
            priv_viol_q <= 1'b0;
            dr_rd_data_q <= 32'h0000_0000;
            ar_rd_data_q <= 32'h0000_0000;
            sw_rd_data_q <= 16'h0000;
            cm_rdata_q <= 32'h0000_0000;
            vec_addr_q <= 32'h0000_0000;
        end
        else
        begin
            // stack pointer 7 follows the privilege level in force
            if (ar_ok && ar_wr_idx == 3'h7 && sup)
                ssp_q <= ar_new;
            if ((ar_ok && ar_wr_idx == 3'h7 && !sup) || (cm_wr_ok && cm_sel == cpr_pkg::CM_USP))
                usp_q <= (cm_wr_ok && cm_sel == cpr_pkg::CM_USP) ? cm_wdata : ar_new;
            if (cm_wr_ok && cm_sel == cpr_pkg::CM_SFC)
                sfc_q <= cm_wdata[2:0];
            if (cm_wr_ok && cm_sel == cpr_pkg::CM_DFC)
                dfc_q <= cm_wdata[2:0];
            if (cm_wr_ok && cm_sel == cpr_pkg::CM_VBR)
                vbr_q <= cm_wdata;
            processor_status_word_q <= sw_d;
            if (pc_load)
                next_instr_pointer_q <= pc_load_val;
            else if (pc_inc)
                next_instr_pointer_q <= next_instr_pointer_q + {28'h000_0000, pc_inc_words, 1'b0};
            size_err_q <= ar_byte;
            priv_viol_q <= cm_deny || sw_deny || alt_deny;
            dr_rd_data_q <= merge(32'h0000_0000, dr_sel, dr_rd_size);
            ar_rd_data_q <= (ar_rd_size == cpr_pkg::SZ_LONG) ? ar_sel : {16'h0000, ar_sel[15:0]};
            sw_rd_data_q <= processor_status_word_q & (sw_ccr_only ? cpr_pkg::SW_CCR_MASK : cpr_pkg::SW_IMPL_MASK);
            if (cm_en && !cm_write && sup)
                cm_rdata_q <= cm_sel_val;
            vec_addr_q <= vbr_q + {22'h00_0000, vec_num, 2'b00};
        end
    end

    // operand bus: 16-bit, long words go high half first then low half
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bs_q <= BS_IDLE;
            bus_req_q <= 1'b0;
            bus_rnw_q <= 1'b1;
            bus_addr_q <= 24'h00_0000;
            bus_fc_q <= 3'h0;
            bus_ustb_q <= 1'b0;
            bus_lstb_q <= 1'b0;
            bus_wdata_q <= 16'h0000;
            bus_hi_q <= 16'h0000;
            bus_lo_data_q <= 16'h0000;
            bus_long_q <= 1'b0;
            bus_byte_q <= 1'b0;
            bus_odd_q <= 1'b0;
            mem_rdata_q <= 32'h0000_0000;
            mem_done_q <= 1'b0;
            mem_busy_q <= 1'b0;
            addr_err_q <= 1'b0;
        end
        else
        begin
            mem_done_q <= 1'b0;
            addr_err_q <= 1'b0;
            unique case (bs_q)
                BS_IDLE:
                begin
                    if (mem_req && !alt_deny && mis)
                        addr_err_q <= 1'b1;
                    else if (mem_req && !alt_deny)
                    begin
                        bs_q <= BS_HI;
                        bus_req_q <= 1'b1;
                        mem_busy_q <= 1'b1;
                        bus_rnw_q <= mem_rnw;
                        bus_addr_q <= mem_addr[23:0];
                        bus_fc_q <= fc_sel;
                        bus_long_q <= mem_size == cpr_pkg::SZ_LONG;
                        bus_byte_q <= mem_size == cpr_pkg::SZ_BYTE;
                        bus_odd_q <= mem_addr[0];
                        bus_ustb_q <= mem_size != cpr_pkg::SZ_BYTE || !mem_addr[0];
                        bus_lstb_q <= mem_size != cpr_pkg::SZ_BYTE || mem_addr[0];
                        bus_wdata_q <= (mem_size == cpr_pkg::SZ_LONG) ? mem_wdata[31:16] :
                                       (mem_size == cpr_pkg::SZ_BYTE) ? {2{mem_wdata[7:0]}} : mem_wdata[15:0];
                        bus_lo_data_q <= mem_wdata[15:0];
                    end
                end
                BS_HI:
                begin
                    if (bus_ack && bus_long_q)
                    begin
                        bs_q <= BS_LO;
                        bus_hi_q <= bus_rdata;
                        bus_addr_q <= bus_addr_q + cpr_pkg::HALF_STEP;
                        bus_wdata_q <= bus_lo_data_q;
                    end
                    else if (bus_ack)
                    begin
                        bs_q <= BS_IDLE;
                        bus_req_q <= 1'b0;
                        mem_busy_q <= 1'b0;
                        mem_done_q <= 1'b1;
                        mem_rdata_q <= bus_byte_q ? {24'h00_0000, rd_lane} : {16'h0000, bus_rdata};
                    end
                end
                BS_LO:
                begin
                    if (bus_ack)
                    begin
                        bs_q <= BS_IDLE;
                        bus_req_q <= 1'b0;
                        mem_busy_q <= 1'b0;
                        mem_done_q <= 1'b1;
                        mem_rdata_q <= {bus_hi_q, bus_rdata};
                    end
                end
            endcase
        end
    end

    // checks
    property p_ar_long;
        @(posedge ref_clk) disable iff (!resetn)
        ar_wr_en && ar_wr_size == cpr_pkg::SZ_LONG && ar_wr_idx < 3'h7 |=> ar_q[$past(ar_wr_idx)] == $past(ar_wr_data);
    endproperty
    a_ar_long: assert property (p_ar_long) else $error("address register long write lost");
    property p_ar_sext;
        @(posedge ref_clk) disable iff (!resetn)
        ar_wr_en && ar_wr_size == cpr_pkg::SZ_WORD && ar_wr_idx < 3'h7 |=>
            ar_q[$past(ar_wr_idx)] == {{16{$past(ar_wr_data[15])}}, $past(ar_wr_data[15:0])};
    endproperty
    a_ar_sext: assert property (p_ar_sext) else $error("word write not sign extended");
    property p_ar_byte;
        @(posedge ref_clk) disable iff (!resetn)
        ar_wr_en && ar_wr_size == cpr_pkg::SZ_BYTE |=> size_err_q ##1 !size_err_q || $past(ar_byte);
    endproperty
    a_ar_byte: assert property (p_ar_byte) else $error("byte address write not refused");
    property p_priv;
        @(posedge ref_clk) disable iff (!resetn)
        cm_en && !sup |=> priv_viol_q && $stable(sfc_q) && $stable(vbr_q);
    endproperty
    a_priv: assert property (p_priv) else $error("user control register access not blocked");
    property p_sw_reserved;
        @(posedge ref_clk) disable iff (!resetn)
        (processor_status_word_q & ~cpr_pkg::SW_IMPL_MASK) == 16'h0000 && (sw_rd_data_q & ~cpr_pkg::SW_IMPL_MASK) == 16'h0000;
    endproperty
    a_sw_reserved: assert property (p_sw_reserved) else $error("undefined status bit set");
    property p_ccr_upper;
        @(posedge ref_clk) disable iff (!resetn)
        sw_wr_en && sw_ccr_only |=> processor_status_word_q[15:8] == $past(processor_status_word_q[15:8]);
    endproperty
    a_ccr_upper: assert property (p_ccr_upper) else $error("condition byte write changed upper byte");
    property p_fc_read;
        @(posedge ref_clk) disable iff (!resetn)
        cm_en && !cm_write && sup && (cm_sel == cpr_pkg::CM_SFC || cm_sel == cpr_pkg::CM_DFC) |=> cm_rdata_q[31:3] == 29'h0;
    endproperty
    a_fc_read: assert property (p_fc_read) else $error("space code upper bits not zero");
    property p_misalign;
        @(posedge ref_clk) disable iff (!resetn)
        bs_q == BS_IDLE && mem_req && !alt_deny && mis |=> addr_err_q && !bus_req_q;
    endproperty
    a_misalign: assert property (p_misalign) else $error("odd word access not aborted");
    sequence s_long_hi_ack;
        bs_q == BS_HI && bus_long_q && bus_ack;
    endsequence
    property p_long_order;
        @(posedge ref_clk) disable iff (!resetn)
        s_long_hi_ack |=> bus_addr_q == $past(bus_addr_q) + cpr_pkg::HALF_STEP && bus_req_q;
    endproperty
    a_long_order: assert property (p_long_order) else $error("low half not at address plus two");
    property p_vec;
        @(posedge ref_clk) disable iff (!resetn)
        ##1 vec_addr_q == $past(vbr_q) + {22'h00_0000, $past(vec_num), 2'b00};
    endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
endmodule : cpr_regs
`default_nettype wire

// ===== hw/cpr_pkg.sv
// Purpose: shared constants and types for the programmer-visible register set
// Assumes: 250 MHz ref_clk, single clock domain
// Notes: status word bit placement and function code values are local choices
package cpr_pkg;
    // operand sizes
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cpr_size_t;
    // control registers reachable by the control register move
    typedef enum logic [1:0] {CM_SFC, CM_DFC, CM_VBR, CM_USP} cpr_ctl_t;
    // status word field positions
    localparam int SW_C_BIT = 0;
    localparam int SW_V_BIT = 1;
    localparam int SW_Z_BIT = 2;
    localparam int SW_N_BIT = 3;
    localparam int SW_X_BIT = 4;
    localparam int SW_IPM_LO = 8;
    localparam int SW_IPM_HI = 10;
    localparam int SW_S_BIT = 13;
    localparam int SW_T_LO = 14;
    localparam int SW_T_HI = 15;
    localparam logic [15:0] SW_IMPL_MASK = 16'hE71F;
    localparam logic [15:0] SW_CCR_MASK = 16'h001F;
    // after reset: supervisor, all interrupts masked, trace off
    localparam logic [15:0] SW_RESET = 16'h2700;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] VBR_RESET = 32'h0000_0000;
    localparam logic [2:0] FC_RESET = 3'h0;
    // function codes
    localparam logic [2:0] FC_USER_DATA = 3'h1;
    localparam logic [2:0] FC_USER_PROG = 3'h2;
    localparam logic [2:0] FC_SUP_DATA = 3'h5;
    localparam logic [2:0] FC_SUP_PROG = 3'h6;
    localparam logic [2:0] FC_CPU_SPACE = 3'h7;
    localparam int NUM_AREGS = 7;
    localparam int NUM_DREGS = 8;
    localparam int BUS_ADDR_W = 24;
    localparam logic [23:0] HALF_STEP = 24'h00_0002;
endpackage : cpr_pkg

// ===== bench/test_cpu_programmer_regs.sv
// Purpose: self-checking bench for the programmer register set
// Assumes: 250 MHz ref_clk, bench drives inputs on the falling edge
// Notes: bench answers bus cycles itself with random stalls; user mode is tested last, a reset leaves it
`timescale 1ns/1ps
`default_nettype none
module test_cpu_programmer_regs;
logic ref_clk, resetn, dr_wr_en, ar_wr_en, pc_load, pc_inc, cc_upd_en, sw_wr_en, sw_rd_en, sw_ccr_only;
logic cm_en, cm_write, mem_req, mem_rnw, mem_prog, mem_cpu_space, mem_alt, bus_ack, size_err_q, priv_viol_q;
logic mem_done_q, mem_busy_q, addr_err_q, bus_req_q, bus_rnw_q, bus_ustb_q, bus_lstb_q, m_err, m_viol, m_done;
logic [2:0] dr_wr_idx, dr_rd_idx, ar_wr_idx, ar_rd_idx, pc_inc_words, bus_fc_q, fc;
cpr_pkg::cpr_size_t dr_wr_size, dr_rd_size, ar_wr_size, ar_rd_size, mem_size, sz;
cpr_pkg::cpr_ctl_t cm_sel;
logic [31:0] dr_wr_data, dr_rd_data_q, ar_wr_data, ar_rd_data_q, pc_load_val, next_instr_pointer_q, cm_wdata;
logic [31:0] cm_rdata_q, vec_addr_q, mem_addr, mem_wdata, mem_rdata_q, m_rd, d, e, u, v, n;
logic [15:0] sw_wr_data, sw_rd_data_q, processor_status_word_q, bus_wdata_q, bus_rdata;
logic [23:0] bus_addr_q;
logic [23:0] sa [2];
logic [15:0] swd [2];
logic [7:0] vec_num;
logic [4:0] cc_upd_val;
int error_cnt = 0;
int n_tests = 0;
int nb;
int i;
int w;
// space code written to the source register, kept for the alternate read check
logic [2:0] sfc_v;
// strobes and direction seen at the first acked bus edge: {upper, lower, read}
logic [2:0] stb;

cpr_regs dut (
    .ref_clk, .resetn, .dr_wr_en, .dr_wr_idx, .dr_wr_size, .dr_wr_data, .dr_rd_idx, .dr_rd_size, .dr_rd_data_q,
    .ar_wr_en, .ar_wr_idx, .ar_wr_size, .ar_wr_data, .ar_rd_idx, .ar_rd_size, .ar_rd_data_q, .size_err_q,
    .pc_load, .pc_load_val, .pc_inc, .pc_inc_words, .next_instr_pointer_q, .cc_upd_en, .cc_upd_val,
    .sw_wr_en, .sw_rd_en, .sw_ccr_only, .sw_wr_data, .sw_rd_data_q, .processor_status_word_q,
    .cm_en, .cm_write, .cm_sel, .cm_wdata, .cm_rdata_q, .priv_viol_q, .vec_num, .vec_addr_q,
    .mem_req, .mem_rnw, .mem_prog, .mem_cpu_space, .mem_alt, .mem_size, .mem_addr, .mem_wdata, .mem_rdata_q,
    .mem_done_q, .mem_busy_q, .addr_err_q, .bus_req_q, .bus_rnw_q, .bus_addr_q, .bus_fc_q, .bus_ustb_q,
    .bus_lstb_q, .bus_wdata_q, .bus_ack, .bus_rdata
);

// read data pattern ignores address bit 0, so a byte address on the bus still matches
function automatic logic [15:0] rdf(input logic [23:0] a);
    return {a[8:1] ^ 8'h5a, a[16:9]};
endfunction : rdf

function automatic logic [31:0] sx(input logic [15:0] h);
    return {{16{h[15]}}, h};
endfunction : sx

task automatic tick;
    @(negedge ref_clk);
endtask : tick

task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
        error_cnt++;
        $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
endtask : check

task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask : give_verdict

task automatic reg_wr(input logic is_a, input logic [2:0] x, input cpr_pkg::cpr_size_t s, input logic [31:0] dv);
    ar_wr_en = is_a;
    dr_wr_en = !is_a;
    ar_wr_idx = x;
    dr_wr_idx = x;
    ar_wr_size = s;
    dr_wr_size = s;
    ar_wr_data = dv;
    dr_wr_data = dv;
    tick();
    ar_wr_en = 1'b0;
    dr_wr_en = 1'b0;
endtask : reg_wr

task automatic reg_rd(input logic [2:0] x, input cpr_pkg::cpr_size_t s);
    ar_rd_idx = x;
    dr_rd_idx = x;
    ar_rd_size = s;
    dr_rd_size = s;
    tick();
endtask : reg_rd

task automatic sw_op(input logic wr, input logic rd, input logic condition_flags_byte, input logic [15:0] dv);
    sw_wr_en = wr;
    sw_rd_en = rd;
    sw_ccr_only = condition_flags_byte;
    sw_wr_data = dv;
    tick();
    sw_wr_en = 1'b0;
    sw_rd_en = 1'b0;
endtask : sw_op

task automatic cm_op(input logic wr, input cpr_pkg::cpr_ctl_t s, input logic [31:0] dv);
    cm_en = 1'b1;
    cm_write = wr;
    cm_sel = s;
    cm_wdata = dv;
    tick();
    cm_en = 1'b0;
endtask : cm_op

// ack comes after a random stall; a bus not acked shows the inverted pattern, never the right data
task automatic mem_op(input logic rnw, input cpr_pkg::cpr_size_t s, input logic [31:0] a, input logic [31:0] wd);
    mem_req = 1'b1;
    mem_rnw = rnw;
    mem_size = s;
    mem_addr = a;
    mem_wdata = wd;
    nb = 0;
    m_done = 1'b0;
    m_err = 1'b0;
    m_viol = 1'b0;
    tick();
    mem_req = 1'b0;
    for (int k = 0; k < 40 && !m_done && !m_err && !m_viol; k++)
    begin
        m_err = addr_err_q;
        m_viol = priv_viol_q;
        m_done = mem_done_q;
        bus_ack = bus_req_q & ($urandom_range(0, 2) != 0);
        bus_rdata = bus_ack ? rdf(bus_addr_q) : ~rdf(bus_addr_q);
        if (bus_ack && nb == 0)
            stb = {bus_ustb_q, bus_lstb_q, bus_rnw_q};
        if (bus_ack && nb < 2)
        begin
            sa[nb] = bus_addr_q;
            swd[nb] = bus_wdata_q;
            fc = bus_fc_q;
        end
        nb += bus_ack;
        if (!m_done && !m_err && !m_viol)
            tick();
    end
    bus_ack = 1'b0;
    m_rd = mem_rdata_q;
endtask : mem_op

initial
begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
end

initial
begin
    #40000;
    error_cnt++;
    give_verdict();
end

initial
begin
    {resetn, dr_wr_en, ar_wr_en, pc_load, pc_inc, cc_upd_en, sw_wr_en, sw_rd_en, sw_ccr_only} = '0;
    {cm_en, cm_write, mem_req, mem_rnw, mem_prog, mem_cpu_space, mem_alt, bus_ack} = '0;
    {dr_wr_idx, dr_rd_idx, ar_wr_idx, ar_rd_idx, pc_inc_words, cc_upd_val, vec_num} = '0;
    {dr_wr_data, ar_wr_data, pc_load_val, cm_wdata, mem_addr, mem_wdata, sw_wr_data, bus_rdata} = '0;
    {dr_wr_size, dr_rd_size, ar_wr_size, ar_rd_size, mem_size} = '0;
    cm_sel = cpr_pkg::CM_SFC;
    void'($urandom(32'h6f58_6a3e));
    repeat (2) tick();
    resetn = 1'b1;
    check("sw_reset", processor_status_word_q, cpr_pkg::SW_RESET);
    check("pc_reset", next_instr_pointer_q, cpr_pkg::PC_RESET);
    for (i = 0; i < 8; i++)
    begin
        d = (i == 0) ? 32'h1234_8000 : $urandom;
        sz = i[0] ? cpr_pkg::SZ_LONG : cpr_pkg::SZ_WORD;
        e = i[0] ? d : sx(d[15:0]);
        reg_wr(1'b1, i[2:0] % 7, sz, d);
        check("ar_size_err", size_err_q, 1'b0);
        reg_rd(i[2:0] % 7, cpr_pkg::SZ_LONG);
        check("ar_long", ar_rd_data_q, e);
        reg_rd(i[2:0] % 7, cpr_pkg::SZ_WORD);
        check("ar_word", ar_rd_data_q, {16'h0000, e[15:0]});
        reg_wr(1'b1, i[2:0] % 7, cpr_pkg::SZ_BYTE, ~d);
        check("ar_byte_err", size_err_q, 1'b1);
        reg_rd(i[2:0] % 7, cpr_pkg::SZ_LONG);
        check("ar_byte_keep", ar_rd_data_q, e);
        u = $urandom;
        reg_wr(1'b0, i[2:0], cpr_pkg::SZ_LONG, d);
        reg_wr(1'b0, i[2:0], i[0] ? cpr_pkg::SZ_WORD : cpr_pkg::SZ_BYTE, u);
        reg_rd(i[2:0], cpr_pkg::SZ_LONG);
        check("dr_keep", dr_rd_data_q, i[0] ? {d[31:16], u[15:0]} : {d[31:8], u[7:0]});
    end
    e = $urandom & 32'h00ff_fffe;
    w = $urandom_range(1, 7);
    pc_load = 1'b1;
    pc_load_val = e;
    tick();
    pc_load = 1'b0;
    pc_inc = 1'b1;
    pc_inc_words = w[2:0];
    tick();
    pc_inc = 1'b0;
    check("pc_step", next_instr_pointer_q, e + 2 * w);
    sw_op(1'b1, 1'b0, 1'b0, 16'hffff);
    check("sw_undef", processor_status_word_q, 16'he71f);
    d = $urandom;
    sw_op(1'b1, 1'b0, 1'b1, {8'hff, d[7:0]});
    check("ccr_upper_ignored", processor_status_word_q, {8'he7, 3'h0, d[4:0]});
    sw_op(1'b0, 1'b1, 1'b1, 16'h0000);
    check("ccr_read", sw_rd_data_q, {11'h000, d[4:0]});
    sw_op(1'b1, 1'b1, 1'b0, 16'h2700);
    cc_upd_en = 1'b1;
    cc_upd_val = d[12:8];
    tick();
    cc_upd_en = 1'b0;
    check("cc_flags", processor_status_word_q, {11'h138, d[12:8]});
    sw_op(1'b0, 1'b1, 1'b0, 16'h0000);
    check("sw_full_read", sw_rd_data_q, {11'h138, d[12:8]});
    for (i = 0; i < 2; i++)
    begin
        v = $urandom;
        cm_op(1'b1, i[0] ? cpr_pkg::CM_DFC : cpr_pkg::CM_SFC, v);
        cm_op(1'b0, i[0] ? cpr_pkg::CM_DFC : cpr_pkg::CM_SFC, 32'h0000_0000);
        check("space_code", cm_rdata_q, {29'h0, v[2:0]});
        if (!i[0])
            sfc_v = v[2:0];
    end
    u = $urandom;
    cm_op(1'b1, cpr_pkg::CM_VBR, u);
    vec_num = 8'hff;
    tick();
    check("vec_top", vec_addr_q, u + 32'h0000_03fc);
    cm_op(1'b1, cpr_pkg::CM_USP, ~u);
    n = $urandom & 32'hffff_fffe;
    d = $urandom;
    mem_op(1'b0, cpr_pkg::SZ_LONG, n, d);
    check("long_done", {m_done, nb[1:0]}, 3'h6);
    check("long_addr_hi", sa[0], n[23:0]);
    check("long_addr_lo", sa[1], n[23:0] + 24'h00_0002);
    check("long_wd", {swd[0], swd[1]}, d);
    check("long_wr_strobes", stb, 3'b110);
    check("fc_sup_data", fc, cpr_pkg::FC_SUP_DATA);
    mem_op(1'b1, cpr_pkg::SZ_LONG, n, 32'h0000_0000);
    check("long_rd", m_rd, {rdf(n[23:0]), rdf(n[23:0] + 24'h00_0002)});
    mem_op(1'b1, cpr_pkg::SZ_BYTE, n | 32'h1, 32'h0000_0000);
    check("byte_odd", m_rd, {16'h0000, rdf(n[23:0]) & 16'h00ff});
    check("byte_odd_strobes", stb, 3'b011);
    mem_op(1'b1, cpr_pkg::SZ_BYTE, n, 32'h0000_0000);
    check("byte_even", m_rd, {16'h0000, rdf(n[23:0]) >> 8});
    check("byte_even_strobes", stb, 3'b101);
    for (i = 0; i < 2; i++)
    begin
        mem_op(i[0], i[0] ? cpr_pkg::SZ_WORD : cpr_pkg::SZ_LONG, n | 32'h1, d);
        check("odd_abort", {m_err, nb[1:0]}, 3'h4);
        mem_alt = 1'b1;
        mem_op(i[0], cpr_pkg::SZ_WORD, n, d);
        mem_alt = 1'b0;
        check("alt_fc", fc, i[0] ? sfc_v : v[2:0]);
    end
    mem_alt = 1'b1;
    mem_op(1'b1, cpr_pkg::SZ_WORD, n, d);
    mem_alt = 1'b0;
    mem_cpu_space = 1'b1;
    mem_op(1'b1, cpr_pkg::SZ_WORD, n, d);
    mem_cpu_space = 1'b0;
    check("fc_cpu", fc, cpr_pkg::FC_CPU_SPACE);
    mem_prog = 1'b1;
    mem_op(1'b1, cpr_pkg::SZ_WORD, n, d);
    check("fc_sup_prog", fc, cpr_pkg::FC_SUP_PROG);
    sw_op(1'b1, 1'b0, 1'b0, 16'h0000);
    mem_op(1'b1, cpr_pkg::SZ_WORD, n, d);
    mem_prog = 1'b0;
    check("fc_user_prog", fc, cpr_pkg::FC_USER_PROG);
    reg_rd(3'h7, cpr_pkg::SZ_LONG);
    check("usp_active", ar_rd_data_q, ~u);
    cm_op(1'b1, cpr_pkg::CM_VBR, 32'h0000_0000);
    check("user_cm_viol", priv_viol_q, 1'b1);
    vec_num = 8'h00;
    tick();
    check("vbr_kept", vec_addr_q, u);
    sw_op(1'b1, 1'b0, 1'b0, 16'h2700);
    check("user_sw_viol", {priv_viol_q, processor_status_word_q}, 17'h1_0000);
    sw_op(1'b1, 1'b0, 1'b1, 16'hff1f);
    check("user_ccr_wr", {priv_viol_q, processor_status_word_q}, 17'h0_001f);
    mem_alt = 1'b1;
    mem_op(1'b1, cpr_pkg::SZ_WORD, n, d);
    mem_alt = 1'b0;
    check("user_alt_viol", {m_viol, nb[1:0]}, 3'h4);
    mem_op(1'b1, cpr_pkg::SZ_WORD, n, d);
    check("fc_user_data", fc, cpr_pkg::FC_USER_DATA);
    resetn = 1'b0;
    repeat (2) tick();
    resetn = 1'b1;
    check("sw_rereset", processor_status_word_q, cpr_pkg::SW_RESET);
    give_verdict();
end
endmodule : test_cpu_programmer_regs
`default_nettype wire
